/* File: verilog/sad_pkg.sv */
// constants and types shared by the sad coprocessor pipeline follower
package sad_pkg;
  // instruction word fields
  localparam int CPNUM_LSB = 8;
  localparam int CPNUM_W = 4;
  localparam logic [3:0] CPNUM_DEFAULT = 4'h7;
  localparam int OPSEL_LSB = 21;
  localparam int REGSEL_LSB = 16;
  localparam int BUFLINE_LSB = 17;
  localparam int BUFWORD_BIT = 16;
  // coprocessor register selects for reg_write_op / reg_read_op
  localparam logic [1:0] CREG_BYTE_OFFSET = 2'h0;
  localparam logic [1:0] CREG_LINE_INDEX = 2'h1;
  localparam logic [1:0] CREG_ACCUM = 2'h2;
  localparam logic [1:0] CREG_CONFIG = 2'h3;
  // handshake codes
  localparam logic [1:0] HS_WAIT = 2'h0;
  localparam logic [1:0] HS_GO = 2'h1;
  localparam logic [1:0] HS_ABSENT = 2'h2;
  localparam logic [1:0] HS_LAST = 2'h3;
  // execute lengths in memory cycles, as last step index
  localparam logic [1:0] LAST_SINGLE = 2'h0;
  localparam logic [1:0] LAST_BUFFER_LOAD = 2'h1;
  localparam logic [1:0] LAST_SAD_ALIGNED = 2'h1;
  localparam logic [1:0] LAST_SAD_SHIFTED = 2'h2;
  // register port map
  localparam logic [1:0] RA_CTRL = 2'h0;
  localparam logic [1:0] RA_STATUS = 2'h1;
  localparam logic [1:0] RA_ACCUM = 2'h2;
  localparam logic RST_INC_FLAG = 1'b0;
  localparam int BUF_LINES = 8;

  typedef enum logic [2:0] {
    SAD_OP_REG_WRITE,
    SAD_OP_REG_READ,
    SAD_OP_BUFFER_READ,
    SAD_OP_BUFFER_LOAD,
    SAD_OP_SAD_LOAD,
    SAD_OP_RSVD5,
    SAD_OP_RSVD6,
    SAD_OP_RSVD7
  } sad_op_e;
endpackage : sad_pkg

/* File: verilog/sad_coproc.sv */
// pipeline follower, handshake and datapath of the sad motion-estimation coprocessor
//
// The placing of the registers and the plain strobed port were chosen for this implementation.

module sad_coproc #(
  parameter logic [3:0] CPNUM = sad_pkg::CPNUM_DEFAULT,
  parameter int ADDR_W = 2
) (
  // clock, enable, reset
  input wire logic core_clk,
  input wire logic core_clock_enable,
  input wire logic reset_n,
  // host instruction interface
  input wire logic [31:0] instruction_word_in,
  input wire logic compressed_state_in,
  input wire logic mem_request_n,
  input wire logic pass_in,
  input wire logic late_cancel_in,
  input wire logic data_abort_in,
  input wire logic big_endian_sel,
  // host data buses
  input wire logic [31:0] write_data_in,
  output logic [31:0] read_data_out,
  // handshakes
  output logic [1:0] decode_handshake,
  output logic [1:0] execute_handshake,
  output logic [1:0] decode_handshake_early,
  output logic [1:0] execute_handshake_early,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // scan
  input wire logic test_scan_clock,
  input wire logic test_scan_in,
  input wire logic test_scan_mode,
  output logic test_scan_out
);

  typedef struct packed {
    logic [31:0] dec_instr;
    logic dec_valid;
    logic [31:0] ex_instr;
    logic ex_valid;
    logic [1:0] ex_step;
    logic ex_abort;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [1:0] byte_offset_reg;
    logic [2:0] line_index_reg;
    logic index_increment_flag;
    logic [31:0] sad_accumulator;
    logic [sad_pkg::BUF_LINES-1:0][1:0][31:0] block_buf;
    logic [31:0] rd_data;
    logic [1:0] hs_de;
    logic [1:0] hs_ex;
    logic [31:0] bus_rdata;
    logic scan_q;
  } sad_state_s;

  sad_state_s state_ff;
  sad_state_s nxt_state;

  // unaligned word: take four bytes starting at the byte offset across two words
  function automatic logic [31:0] sad_combine(input logic [31:0] lo_w, input logic [31:0] hi_w,
                                              input logic [1:0] off, input logic be);
    logic [63:0] pair;
    logic [5:0] sh;
    pair = 64'h0;
    sh = {1'b0, off, 3'h0};
    if (be) begin
      pair = {lo_w, hi_w} << sh;
      sad_combine = pair[63:32];
    end else begin
      pair = {hi_w, lo_w} >> sh;
      sad_combine = pair[31:0];
    end
  endfunction : sad_combine

  function automatic logic [31:0] sad_word(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    acc = 32'h0;
    x = 8'h0;
    y = 8'h0;
    for (int i = 0; i < 4; i++) begin
      x = a[8*i +: 8];
      y = b[8*i +: 8];
      acc = acc + 32'((x > y) ? (x - y) : (y - x));
    end
    sad_word = acc;
  endfunction : sad_word

  function automatic logic [1:0] sad_last(input logic [31:0] instr, input logic [1:0] off);
    logic [2:0] op;
    op = instr[sad_pkg::OPSEL_LSB +: 3];
    if (op == 3'(sad_pkg::SAD_OP_BUFFER_LOAD)) begin
      sad_last = sad_pkg::LAST_BUFFER_LOAD;
    end else if (op == 3'(sad_pkg::SAD_OP_SAD_LOAD)) begin
      sad_last = (off == 2'h0) ? sad_pkg::LAST_SAD_ALIGNED : sad_pkg::LAST_SAD_SHIFTED;
    end else begin
      sad_last = sad_pkg::LAST_SINGLE;
    end
  endfunction : sad_last

  sad_pkg::sad_op_e ex_op;
  logic [1:0] ex_last;
  logic ex_run;
  logic ex_cancel;
  logic ex_bad;
  logic [31:0] ex_first;
  logic [31:0] ex_second;
  logic [2:0] ex_line;
  logic [1:0] ex_reg;
  logic [31:0] creg_val;
  logic instr_ours;

  assign ex_op = sad_pkg::sad_op_e'(state_ff.ex_instr[sad_pkg::OPSEL_LSB +: 3]);
  assign ex_reg = state_ff.ex_instr[sad_pkg::REGSEL_LSB +: 2];
  assign ex_line = state_ff.ex_instr[sad_pkg::BUFLINE_LSB +: 3];
  assign ex_last = sad_last(state_ff.ex_instr, state_ff.byte_offset_reg);
  // only the defined opcodes are taken; in compressed state nothing is ours
  assign instr_ours = (instruction_word_in[sad_pkg::CPNUM_LSB +: sad_pkg::CPNUM_W] == CPNUM)
                      && (instruction_word_in[sad_pkg::OPSEL_LSB +: 3] <= 3'(sad_pkg::SAD_OP_SAD_LOAD))
                      && !compressed_state_in;

  always_comb begin
    unique case (ex_reg)
      sad_pkg::CREG_BYTE_OFFSET: creg_val = {30'h0, state_ff.byte_offset_reg};
      sad_pkg::CREG_LINE_INDEX: creg_val = {29'h0, state_ff.line_index_reg};
      sad_pkg::CREG_ACCUM: creg_val = state_ff.sad_accumulator;
      sad_pkg::CREG_CONFIG: creg_val = {31'h0, state_ff.index_increment_flag};
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    // pass is only looked at in the first step; later steps run on the enable alone,
    // so a host that drops pass mid-load cannot strand a half-filled temporary
    ex_run = core_clock_enable && state_ff.ex_valid && ((state_ff.ex_step != 2'h0) || pass_in);
    ex_cancel = (state_ff.ex_step == 2'h0) && late_cancel_in;
    ex_bad = ex_cancel || state_ff.ex_abort || data_abort_in;
    if (state_ff.byte_offset_reg == 2'h0) begin
      ex_first = state_ff.w0;
      ex_second = write_data_in;
    end else begin
      ex_first = sad_combine(state_ff.w0, state_ff.w1, state_ff.byte_offset_reg, big_endian_sel);
      ex_second = sad_combine(state_ff.w1, write_data_in, state_ff.byte_offset_reg, big_endian_sel);
    end

    // register port: control writes steer the index increment
    if (reg_wr && (reg_addr == ADDR_W'(sad_pkg::RA_CTRL))) begin
      nxt_state.index_increment_flag = reg_wdata[0];
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_W'(sad_pkg::RA_CTRL)) begin
        nxt_state.bus_rdata = {31'h0, state_ff.index_increment_flag};
      end else if (reg_addr == ADDR_W'(sad_pkg::RA_STATUS)) begin
        nxt_state.bus_rdata = {24'h0, state_ff.dec_valid, state_ff.ex_valid,
                               state_ff.byte_offset_reg, 1'b0, state_ff.line_index_reg};
      end else if (reg_addr == ADDR_W'(sad_pkg::RA_ACCUM)) begin
        nxt_state.bus_rdata = state_ff.sad_accumulator;
      end else begin
        nxt_state.bus_rdata = 32'h0;
      end
    end

    if (ex_run) begin
      unique case (ex_op)
        sad_pkg::SAD_OP_REG_WRITE: begin
          if (!ex_cancel) begin
            unique case (ex_reg)
              sad_pkg::CREG_BYTE_OFFSET: nxt_state.byte_offset_reg = write_data_in[1:0];
              sad_pkg::CREG_LINE_INDEX: nxt_state.line_index_reg = write_data_in[2:0];
              sad_pkg::CREG_ACCUM: nxt_state.sad_accumulator = write_data_in;
              sad_pkg::CREG_CONFIG: nxt_state.index_increment_flag = write_data_in[0];
            endcase
          end
        end
        sad_pkg::SAD_OP_REG_READ: begin
          if (!ex_cancel) begin
            nxt_state.rd_data = creg_val;
          end
        end
        sad_pkg::SAD_OP_BUFFER_READ: begin
          if (!ex_cancel) begin
            nxt_state.rd_data = state_ff.block_buf[ex_line][state_ff.ex_instr[sad_pkg::BUFWORD_BIT]];
          end
        end
        sad_pkg::SAD_OP_BUFFER_LOAD: begin
          if (state_ff.ex_step == 2'h0) begin
            nxt_state.w0 = write_data_in;
          end else if (!ex_bad) begin
            nxt_state.block_buf[state_ff.line_index_reg][0] = state_ff.w0;
            nxt_state.block_buf[state_ff.line_index_reg][1] = write_data_in;
            if (state_ff.index_increment_flag) begin
              nxt_state.line_index_reg = state_ff.line_index_reg + 3'h1;
            end
          end
        end
        sad_pkg::SAD_OP_SAD_LOAD: begin
          if (state_ff.ex_step == 2'h0) begin
            nxt_state.w0 = write_data_in;
          end else if (state_ff.ex_step != ex_last) begin
            nxt_state.w1 = write_data_in;
          end else if (!ex_bad) begin
            // temporaries are only folded into the accumulator once all loads survived
            nxt_state.sad_accumulator = state_ff.sad_accumulator
              + sad_word(ex_first, state_ff.block_buf[state_ff.line_index_reg][0])
              + sad_word(ex_second, state_ff.block_buf[state_ff.line_index_reg][1]);
            if (state_ff.index_increment_flag) begin
              nxt_state.line_index_reg = state_ff.line_index_reg + 3'h1;
            end
          end
        end
        default: begin
          nxt_state.ex_abort = 1'b0;
        end
      endcase
      if ((state_ff.ex_step == ex_last) || ex_cancel) begin
        nxt_state.ex_valid = 1'b0;
        nxt_state.ex_step = 2'h0;
        nxt_state.ex_abort = 1'b0;
      end else begin
        nxt_state.ex_step = state_ff.ex_step + 2'h1;
        nxt_state.ex_abort = ex_bad;
      end
    end

    if (core_clock_enable && !mem_request_n) begin
      nxt_state.ex_instr = state_ff.dec_instr;
      nxt_state.ex_valid = state_ff.dec_valid;
      nxt_state.ex_step = 2'h0;
      nxt_state.ex_abort = 1'b0;
      nxt_state.dec_instr = instruction_word_in;
      nxt_state.dec_valid = instr_ours;
    end

    // handshakes follow the next pipeline contents
    nxt_state.hs_de = nxt_state.dec_valid ? sad_pkg::HS_GO : sad_pkg::HS_ABSENT;
    if (!nxt_state.ex_valid) begin
      nxt_state.hs_ex = sad_pkg::HS_ABSENT;
    end else if (nxt_state.ex_step == sad_last(nxt_state.ex_instr, nxt_state.byte_offset_reg)) begin
      nxt_state.hs_ex = sad_pkg::HS_LAST;
    end else begin
      nxt_state.hs_ex = sad_pkg::HS_GO;
    end
    nxt_state.scan_q = test_scan_mode & test_scan_in;
  end

  // scan chain is inserted later; scan clock is not used by functional logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
      state_ff.hs_de <= sad_pkg::HS_ABSENT;
      state_ff.hs_ex <= sad_pkg::HS_ABSENT;
      state_ff.index_increment_flag <= sad_pkg::RST_INC_FLAG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign read_data_out = state_ff.rd_data;
  assign decode_handshake = state_ff.hs_de;
  assign execute_handshake = state_ff.hs_ex;
  assign decode_handshake_early = nxt_state.hs_de;
  assign execute_handshake_early = nxt_state.hs_ex;
  assign reg_rdata = state_ff.bus_rdata;
  assign test_scan_out = state_ff.scan_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_EARLY_HS: assert property (execute_handshake == $past(execute_handshake_early) &&
                                 decode_handshake == $past(decode_handshake_early))
    else $error("early handshake copy does not lead registered handshake");
  AST_ADVANCE: assert property (core_clock_enable && !mem_request_n |=>
                                state_ff.dec_instr == $past(instruction_word_in) &&
                                state_ff.ex_instr == $past(state_ff.dec_instr))
    else $error("pipeline did not advance on request");
  AST_HOLD_NO_CE: assert property (!core_clock_enable |=> $stable(state_ff.sad_accumulator) &&
                                   $stable(state_ff.line_index_reg) && $stable(state_ff.ex_step))
    else $error("state moved without clock enable");
  AST_EX_ABSENT: assert property (!state_ff.ex_valid |-> execute_handshake == sad_pkg::HS_ABSENT)
    else $error("execute handshake without instruction");
  AST_COMPRESSED: assert property (core_clock_enable && !mem_request_n && compressed_state_in |=>
                              !state_ff.dec_valid)
    else $error("instruction accepted in compressed state");
  AST_NO_PASS: assert property (state_ff.ex_valid && state_ff.ex_step == 2'h0 && !pass_in &&
                                mem_request_n |=> state_ff.ex_valid && state_ff.ex_step == 2'h0)
    else $error("unpassed instruction executed");
  AST_LATE_CANCEL: assert property (ex_run && ex_cancel && mem_request_n |=>
                                    $stable(state_ff.sad_accumulator) && !state_ff.ex_valid &&
                                    $stable(state_ff.byte_offset_reg))
    else $error("late cancel changed state");
  AST_SAD_LEN: assert property (ex_run && ex_op == sad_pkg::SAD_OP_SAD_LOAD && !ex_cancel &&
                                state_ff.ex_step == 2'h0 && mem_request_n &&
                                state_ff.byte_offset_reg != 2'h0 ##1 core_clock_enable &&
                                mem_request_n |-> state_ff.ex_valid ##1 state_ff.ex_step == 2'h2)
    else $error("shifted sad load shorter than three cycles");
  AST_BL_LEN: assert property (ex_run && ex_op == sad_pkg::SAD_OP_BUFFER_LOAD && !ex_cancel &&
                               state_ff.ex_step == 2'h0 && mem_request_n |=>
                               state_ff.ex_valid && execute_handshake == sad_pkg::HS_LAST)
    else $error("buffer load not two cycles long");
  AST_ABORT: assert property (ex_run && data_abort_in && ex_op == sad_pkg::SAD_OP_SAD_LOAD &&
                              state_ff.ex_step == ex_last |=> $stable(state_ff.sad_accumulator))
    else $error("aborted sad load updated accumulator");
  AST_READ: assert property (ex_run && !ex_cancel && ex_op == sad_pkg::SAD_OP_REG_READ |=>
                             read_data_out == $past(creg_val))
    else $error("read data wrong");

  COV_SAD_SHIFTED: cover property (ex_run && ex_op == sad_pkg::SAD_OP_SAD_LOAD &&
                                   state_ff.ex_step == sad_pkg::LAST_SAD_SHIFTED);
  COV_BUF_LOAD: cover property (ex_run && ex_op == sad_pkg::SAD_OP_BUFFER_LOAD &&
                                state_ff.ex_step == sad_pkg::LAST_BUFFER_LOAD && !ex_bad);
  COV_CANCEL: cover property (ex_run && ex_cancel);
  COV_ABORT: cover property (ex_run && data_abort_in);

endmodule : sad_coproc

/* File: tb/sad_host_model.sv */
// behavioural host core driving the coprocessor instruction and data interface
module sad_host_model (
  // clock
  input wire logic core_clk,
  // handshakes from the coprocessor
  input wire logic [1:0] decode_handshake_early,
  input wire logic [1:0] execute_handshake,
  // instruction side toward the coprocessor
  output logic [31:0] instruction_word_in,
  output logic mem_request_n,
  output logic pass_in,
  output logic late_cancel_in,
  output logic data_abort_in,
  // data toward the coprocessor
  output logic [31:0] write_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // coprocessor number field is zero, so this word is never claimed
  localparam logic [31:0] BUBBLE = 32'h0;
  logic [1:0] dec_early_seen;

  initial begin
    instruction_word_in = BUBBLE;
    mem_request_n = 1'b1;
    pass_in = 1'b0;
    late_cancel_in = 1'b0;
    data_abort_in = 1'b0;
    write_data_in = 32'h0;
    dec_early_seen = 2'h0;
  end

  task automatic advance(input logic [31:0] op);
    @(posedge core_clk);
    mem_request_n <= 1'b0;
    instruction_word_in <= op;
    @(negedge core_clk);
    dec_early_seen = decode_handshake_early;
  endtask : advance

  task automatic run_op(input logic [31:0] op, input logic [95:0] w, input logic cancel,
                        input logic abort, output logic [7:0] trace);
    int k;
    logic [1:0] hs;
    trace = 8'hff;
    k = 0;
    advance(op);
    // a spacer between any two of our ops keeps every dependency gap
    advance(BUBBLE);
    @(posedge core_clk);
    mem_request_n <= 1'b1;
    pass_in <= 1'b1;
    late_cancel_in <= cancel;
    data_abort_in <= abort;
    write_data_in <= w[31:0];
    while (k < 3) begin
      @(negedge core_clk);
      hs = execute_handshake;
      trace[2*k +: 2] = hs;
      @(posedge core_clk);
      late_cancel_in <= 1'b0;
      k++;
      if (hs != sad_pkg::HS_GO) begin
        break;
      end
      write_data_in <= w[32*k +: 32];
    end
    pass_in <= 1'b0;
    data_abort_in <= 1'b0;
    // a released bus must not keep looking like valid data
    write_data_in <= ~write_data_in;
    @(negedge core_clk);
    trace[2*k +: 2] = execute_handshake;
  endtask : run_op
endmodule : sad_host_model

/* File: tb/sad_coproc_pipeline_follower_bench.sv */
// self-checking bench for the sad coprocessor pipeline follower
module sad_coproc_pipeline_follower_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] OP_WR = sad_pkg::SAD_OP_REG_WRITE;
  localparam logic [2:0] OP_RD = sad_pkg::SAD_OP_REG_READ;
  localparam logic [2:0] OP_BR = sad_pkg::SAD_OP_BUFFER_READ;
  localparam logic [2:0] OP_BL = sad_pkg::SAD_OP_BUFFER_LOAD;
  localparam logic [2:0] OP_SL = sad_pkg::SAD_OP_SAD_LOAD;
  logic core_clk, reset_n, core_clock_enable, compressed_state_in, reg_wr, reg_rd;
  logic big_endian_sel, scan_out;
  logic mem_request_n, pass_in, late_cancel_in, data_abort_in;
  logic [1:0] reg_addr, decode_handshake, execute_handshake;
  logic [1:0] decode_handshake_early, execute_handshake_early;
  logic [31:0] reg_wdata, reg_rdata, read_data_out, instruction_word_in, write_data_in, rd;
  logic [7:0] tr;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  sad_coproc i_sad_coproc (.core_clk(core_clk), .core_clock_enable(core_clock_enable),
    .reset_n(reset_n), .instruction_word_in(instruction_word_in),
    .compressed_state_in(compressed_state_in), .mem_request_n(mem_request_n),
    .pass_in(pass_in), .late_cancel_in(late_cancel_in), .data_abort_in(data_abort_in),
    .big_endian_sel(big_endian_sel), .write_data_in(write_data_in), .read_data_out(read_data_out),
    .decode_handshake(decode_handshake), .execute_handshake(execute_handshake),
    .decode_handshake_early(decode_handshake_early),
    .execute_handshake_early(execute_handshake_early), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .test_scan_clock(1'b0), .test_scan_in(1'b1), .test_scan_mode(1'b1), .test_scan_out(scan_out));

  sad_host_model i_sad_host_model (.core_clk(core_clk),
    .decode_handshake_early(decode_handshake_early), .execute_handshake(execute_handshake),
    .instruction_word_in(instruction_word_in), .mem_request_n(mem_request_n),
    .pass_in(pass_in), .late_cancel_in(late_cancel_in), .data_abort_in(data_abort_in),
    .write_data_in(write_data_in));

  function automatic logic [31:0] mk(input logic [2:0] op, input logic [3:0] f);
    mk = {8'h00, op, 1'b0, f, 4'h0, sad_pkg::CPNUM_DEFAULT, 8'h00};
  endfunction : mk

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : reg_read

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // whole sequence needs under two hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    core_clock_enable = 1'b1;
    compressed_state_in = 1'b0;
    big_endian_sel = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 32'h0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check("dec_hs", {30'h0, decode_handshake}, 32'(sad_pkg::HS_ABSENT));
    check("ex_hs", {30'h0, execute_handshake}, 32'(sad_pkg::HS_ABSENT));
    check("rdo", read_data_out, 32'h0);
    i_sad_host_model.run_op(mk(OP_WR, 4'h2), 96'h5, 1'b0, 1'b0, tr);
    check("wr_trace", {24'h0, tr}, 32'hfb);
    i_sad_host_model.run_op(mk(OP_RD, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    check("acc", read_data_out, 32'h5);
    reg_read(sad_pkg::RA_ACCUM, rd);
    check("acc_port", rd, 32'h5);
    // cancelled write must leave the accumulator alone
    i_sad_host_model.run_op(mk(OP_WR, 4'h2), 96'h77, 1'b1, 1'b0, tr);
    i_sad_host_model.run_op(mk(OP_RD, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    check("acc_cancel", read_data_out, 32'h5);
    i_sad_host_model.run_op(mk(OP_WR, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    i_sad_host_model.run_op(mk(OP_BL, 4'h0), {32'h0, 32'h02020202, 32'h01010101}, 1'b0,
                            1'b0, tr);
    check("bl_trace", {24'h0, tr}, 32'hed);
    i_sad_host_model.run_op(mk(OP_BR, 4'h1), 96'h0, 1'b0, 1'b0, tr);
    check("buf_w1", read_data_out, 32'h02020202);
    i_sad_host_model.run_op(mk(OP_BL, 4'h0), {32'h0, 32'hdeadbeef, 32'hdeadbeef}, 1'b0,
                            1'b1, tr);
    i_sad_host_model.run_op(mk(OP_BR, 4'h0), 96'h0, 1'b0, 1'b0, tr);
    check("buf_abort", read_data_out, 32'h01010101);
    // uniform bytes keep the sums independent of byte order
    i_sad_host_model.run_op(mk(OP_SL, 4'h0), {32'h0, 32'h05050505, 32'h04040404}, 1'b0,
                            1'b0, tr);
    check("sl0_trace", {24'h0, tr}, 32'hed);
    i_sad_host_model.run_op(mk(OP_RD, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    check("acc_sad0", read_data_out, 32'h18);
    i_sad_host_model.run_op(mk(OP_WR, 4'h0), 96'h1, 1'b0, 1'b0, tr);
    i_sad_host_model.run_op(mk(OP_SL, 4'h0), {3{32'h03030303}}, 1'b0, 1'b0, tr);
    check("sl1_trace", {24'h0, tr}, 32'hb5);
    i_sad_host_model.run_op(mk(OP_RD, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    check("acc_sad1", read_data_out, 32'h24);
    i_sad_host_model.run_op(mk(OP_WR, 4'h0), 96'h0, 1'b0, 1'b0, tr);
    reg_write(2'h3, 32'hffffffff);
    reg_read(2'h3, rd);
    check("unmapped", rd, 32'h0);
    reg_write(sad_pkg::RA_CTRL, 32'h1);
    reg_read(sad_pkg::RA_CTRL, rd);
    check("ctrl", rd, 32'h1);
    i_sad_host_model.run_op(mk(OP_BL, 4'h0), 96'h0, 1'b0, 1'b0, tr);
    reg_read(sad_pkg::RA_STATUS, rd);
    check("idx_bl", {29'h0, rd[2:0]}, 32'h1);
    i_sad_host_model.run_op(mk(OP_SL, 4'h0), 96'h0, 1'b0, 1'b0, tr);
    reg_read(sad_pkg::RA_STATUS, rd);
    check("idx_sl", {29'h0, rd[2:0]}, 32'h2);
    // one marked byte in the first word tells the two byte orders apart
    @(posedge core_clk);
    big_endian_sel <= 1'b1;
    i_sad_host_model.run_op(mk(OP_WR, 4'h0), 96'h1, 1'b0, 1'b0, tr);
    i_sad_host_model.run_op(mk(OP_SL, 4'h0), 96'h10, 1'b0, 1'b0, tr);
    i_sad_host_model.run_op(mk(OP_RD, 4'h2), 96'h0, 1'b0, 1'b0, tr);
    check("acc_be", read_data_out, 32'h34);
    @(posedge core_clk);
    compressed_state_in <= 1'b1;
    i_sad_host_model.advance(mk(OP_RD, 4'h2));
    @(posedge core_clk);
    compressed_state_in <= 1'b0;
    @(negedge core_clk);
    check("dec_compressed", {30'h0, decode_handshake}, 32'(sad_pkg::HS_ABSENT));
    i_sad_host_model.advance(mk(OP_RD, 4'h2));
    check("dec_early", {30'h0, i_sad_host_model.dec_early_seen}, 32'(sad_pkg::HS_GO));
    check("dec_go", {30'h0, decode_handshake}, 32'(sad_pkg::HS_GO));
    check("ex_early", {30'h0, execute_handshake_early}, 32'(sad_pkg::HS_LAST));
    @(posedge core_clk);
    core_clock_enable <= 1'b0;
    i_sad_host_model.advance(32'h0);
    @(posedge core_clk);
    @(negedge core_clk);
    check("dec_hold", {30'h0, decode_handshake}, 32'(sad_pkg::HS_GO));
    @(posedge core_clk);
    core_clock_enable <= 1'b1;
    // no edge passes between the reset and the look
    @(posedge core_clk);
    reset_n <= 1'b0;
    #1;
    check("rdo_async", read_data_out, 32'h0);
    check("ex_async", {30'h0, execute_handshake}, 32'(sad_pkg::HS_ABSENT));
    check("scan_async", {31'h0, scan_out}, 32'h0);
    finish_test();
  end
endmodule : sad_coproc_pipeline_follower_bench
